/* include/shcc_pkg.sv */
// Package for the system handler configuration and control block.
// Assumes a 32-bit APB slave with word-aligned register offsets.
package shcc_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SHCC_OFF_CFG = 8'h00;
	localparam logic [7:0] SHCC_OFF_PRI1 = 8'h04;
	localparam logic [7:0] SHCC_OFF_PRI2 = 8'h08;
	localparam logic [7:0] SHCC_OFF_PRI3 = 8'h0C;
	localparam logic [7:0] SHCC_OFF_HCS = 8'h10;
	localparam logic [7:0] SHCC_OFF_EVT = 8'h14;

	// ----------------------------------------------------------------
	// Configuration control bit positions
	// ----------------------------------------------------------------
	localparam int SHCC_CFG_THREAD = 0;
	localparam int SHCC_CFG_UNPRIV = 1;
	localparam int SHCC_CFG_UNALIGN = 3;
	localparam int SHCC_CFG_DIVZ = 4;
	localparam int SHCC_CFG_BFIGN = 8;
	localparam int SHCC_CFG_STKAL = 9;
	localparam logic [31:0] SHCC_CFG_MASK = 32'h0000031B;
	localparam logic [31:0] SHCC_CFG_RESET = 32'h00000000;

	// ----------------------------------------------------------------
	// Priority field layout: only upper nibble of each priority byte is kept
	// ----------------------------------------------------------------
	localparam logic [31:0] SHCC_PRI1_MASK = 32'h00F0F0F0;
	localparam logic [31:0] SHCC_PRI2_MASK = 32'hF0000000;
	localparam logic [31:0] SHCC_PRI3_MASK = 32'hF0F00000;

	// ----------------------------------------------------------------
	// Handler control and state bit positions
	// ----------------------------------------------------------------
	localparam int SHCC_HCS_MEMACT = 0;
	localparam int SHCC_HCS_BUSACT = 1;
	localparam int SHCC_HCS_USGACT = 3;
	localparam int SHCC_HCS_SVCACT = 7;
	localparam int SHCC_HCS_MONACT = 8;
	localparam int SHCC_HCS_PSVACT = 10;
	localparam int SHCC_HCS_TICKACT = 11;
	localparam int SHCC_HCS_USGPND = 12;
	localparam int SHCC_HCS_MEMPND = 13;
	localparam int SHCC_HCS_BUSPND = 14;
	localparam int SHCC_HCS_SVCPND = 15;
	localparam int SHCC_HCS_MEMENA = 16;
	localparam int SHCC_HCS_BUSENA = 17;
	localparam int SHCC_HCS_USGENA = 18;
	localparam logic [31:0] SHCC_HCS_MASK = 32'h0007FD8B;
	localparam logic [31:0] SHCC_HCS_ACT_MASK = 32'h00000D8B;

	// ----------------------------------------------------------------
	// Event status bits (sticky, write one to clear)
	// ----------------------------------------------------------------
	localparam int SHCC_EVT_LOCKUP = 0;
	localparam int SHCC_EVT_HARD = 1;
	localparam logic [31:0] SHCC_EVT_MASK = 32'h00000003;

	// Stacked status word alignment flag position
	localparam int SHCC_PSR_ALIGN = 9;
	localparam logic [31:0] SHCC_ZERO = 32'h00000000;
	localparam logic [31:0] SHCC_WORD_ALIGN = 32'hFFFFFFFC;
	localparam logic [31:0] SHCC_DWORD_ALIGN = 32'hFFFFFFF8;
	localparam logic [31:0] SHCC_FOUR = 32'h00000004;

	// Fault kinds presented by the core
	localparam logic [1:0] SHCC_FK_MEM = 2'h0;
	localparam logic [1:0] SHCC_FK_BUS = 2'h1;
	localparam logic [1:0] SHCC_FK_USG = 2'h2;

	// APB access phase states
	typedef enum logic [1:0] {
		SHCC_IDLE = 2'b01,
		SHCC_ACC = 2'b10
	} shcc_state_e;

endpackage

/* core/shcc_top.sv */
// System handler configuration and control: APB register file plus the
// exception-side decisions driven by it (traps, alignment, escalation).
// Assumes the core presents one-cycle request strobes on clk_sys.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Alignment bit picks four or eight bytes
// - Record realignment in stacked bit nine
// - Ignore bit masks high-priority bus faults, else lockup
// - Divide trap bit faults zero divisor
// - Untrapped zero divide yields zero quotient
// - Unaligned trap bit faults unaligned accesses
// - Unaligned multiple and double always fault
// - Access bit gates unprivileged trigger writes
// - Thread entry bit relaxes thread return
// - Three byte-accessible priority registers, 0..15
// - First register holds three fault priorities
// - Second register holds supervisor call priority
// - Third register holds tick and pendable
// - Only upper nibble stored, low reads zero
// - Enable bits for usage, bus, memory
// - Writable pending bits at 15 to 12
// - Writable active bits for seven handlers
// - Disabled fault escalates to hard fault
module shcc_top
	import shcc_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic entry_req, // Exception entry strobe
	input wire logic [31:0] entry_sp, // Stack pointer at entry
	input wire logic [31:0] entry_psr, // Status word to stack
	output logic [31:0] entry_sp_out, // Aligned frame pointer
	output logic [31:0] entry_psr_out, // Stacked status word
	input wire logic return_req, // Exception return strobe
	input wire logic [31:0] return_sp, // Frame top at return
	input wire logic [31:0] return_psr, // Unstacked status word
	output logic [31:0] return_sp_out, // Restored stack pointer
	input wire logic thread_ret_req, // Return to thread asked
	input wire logic others_active, // Other exceptions active
	output logic thread_ret_ok, // Thread return allowed
	input wire logic div_req, // Divide issued
	input wire logic [31:0] div_num, // Dividend
	input wire logic [31:0] div_den, // Divisor
	input wire logic div_signed, // Signed divide
	output logic [31:0] div_quot, // Quotient
	output logic div_fault, // Divide by zero fault
	input wire logic mem_req, // Memory access issued
	input wire logic [1:0] mem_size, // 0 byte, 1 half, 2 word
	input wire logic mem_multi, // Multiple or double access
	input wire logic [1:0] mem_addr_lo, // Low address bits
	output logic unalign_fault, // Usage fault, unaligned
	input wire logic dbus_err, // Data bus fault on load/store
	input wire logic high_prio, // Running at -1 or -2
	output logic bus_err_drop, // Bus fault ignored
	output logic lockup, // Core lock-up request
	input wire logic fault_req, // Configurable fault raised
	input wire logic [1:0] fault_kind, // Which fault
	output logic fault_taken, // Handled by own handler
	output logic hard_fault, // Escalated to hard fault
	input wire logic trig_req, // Trigger register write
	input wire logic trig_priv, // Writer is privileged
	output logic trig_grant // Trigger write accepted
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte-lane merge under strobes and a field mask
	function automatic logic [31:0] shcc_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st, input logic [31:0] m);
		logic [31:0] be;
		be = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
		shcc_merge = ((old & ~be) | (wd & be)) & m;
	endfunction

	// Unsigned magnitude of a possibly signed operand
	function automatic logic [31:0] shcc_mag(input logic [31:0] v,
		input logic s);
		shcc_mag = (s && v[31]) ? (SHCC_ZERO - v) : v;
	endfunction

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [31:0] config_control;
	logic [31:0] handler_priority_one;
	logic [31:0] handler_priority_two;
	logic [31:0] handler_priority_three;
	logic [31:0] handler_control_state;
	logic [31:0] event_status;
	shcc_state_e state;
	logic wr_acc;
	logic rd_acc;
	logic lockup_evt;
	logic hard_evt;
	logic fault_ena;
	logic [31:0] next_quot;
	logic [31:0] mag_q;
	logic misaligned;

	assign wr_acc = psel && penable && pwrite && pready;
	assign rd_acc = psel && penable && !pwrite && pready;

	// ----------------------------------------------------------------
	// APB handshake: one wait state, ready on second access cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= SHCC_IDLE;
			pready <= 1'b0;
		end else begin
			case (state)
				SHCC_IDLE: begin
					pready <= 1'b0;
					if (psel && penable) begin
						state <= SHCC_ACC;
						pready <= 1'b1;
					end
				end
				SHCC_ACC: begin
					state <= SHCC_IDLE;
					pready <= 1'b0;
				end
				default: begin
					state <= SHCC_IDLE;
					pready <= 1'b0;
				end
			endcase
		end
	end

	// Configuration register, reserved bits held at zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			config_control <= SHCC_CFG_RESET;
		end else if (wr_acc && paddr == SHCC_OFF_CFG) begin
			config_control <= shcc_merge(config_control, pwdata, pstrb,
				SHCC_CFG_MASK);
		end
	end

	// Priority registers take byte writes; low nibbles never stored
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			handler_priority_one <= SHCC_ZERO;
			handler_priority_two <= SHCC_ZERO;
			handler_priority_three <= SHCC_ZERO;
		end else if (wr_acc) begin
			if (paddr == SHCC_OFF_PRI1) begin
				handler_priority_one <= shcc_merge(handler_priority_one,
					pwdata, pstrb, SHCC_PRI1_MASK);
			end else if (paddr == SHCC_OFF_PRI2) begin
				handler_priority_two <= shcc_merge(handler_priority_two,
					pwdata, pstrb, SHCC_PRI2_MASK);
			end else if (paddr == SHCC_OFF_PRI3) begin
				handler_priority_three <= shcc_merge(handler_priority_three,
					pwdata, pstrb, SHCC_PRI3_MASK);
			end
		end
	end

	// Handler control and state: enables, pending and active bits.
	// A fault taken by its own handler sets its pending bit; the set
	// wins over a software write in the same cycle.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			handler_control_state <= SHCC_ZERO;
		end else begin
			logic [31:0] nv;
			nv = handler_control_state;
			if (wr_acc && paddr == SHCC_OFF_HCS) begin
				nv = shcc_merge(handler_control_state, pwdata, pstrb,
					SHCC_HCS_MASK);
			end
			if (fault_req && fault_ena) begin
				case (fault_kind)
					SHCC_FK_MEM: nv[SHCC_HCS_MEMPND] = 1'b1;
					SHCC_FK_BUS: nv[SHCC_HCS_BUSPND] = 1'b1;
					SHCC_FK_USG: nv[SHCC_HCS_USGPND] = 1'b1;
					default: nv = nv;
				endcase
			end
			handler_control_state <= nv;
		end
	end

	// Sticky event flags, write one to clear, set beats clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			event_status <= SHCC_ZERO;
		end else begin
			logic [31:0] ev;
			ev = event_status;
			if (wr_acc && paddr == SHCC_OFF_EVT) begin
				ev = ev & ~(pwdata & SHCC_EVT_MASK);
			end
			ev[SHCC_EVT_LOCKUP] = ev[SHCC_EVT_LOCKUP] | lockup_evt;
			ev[SHCC_EVT_HARD] = ev[SHCC_EVT_HARD] | hard_evt;
			event_status <= ev;
		end
	end

	// Read mux; unmapped addresses read zero and signal an error
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prdata <= SHCC_ZERO;
			pslverr <= 1'b0;
		end else if (psel && penable && state == SHCC_IDLE) begin
			pslverr <= 1'b0;
			if (paddr == SHCC_OFF_CFG) begin
				prdata <= config_control;
			end else if (paddr == SHCC_OFF_PRI1) begin
				prdata <= handler_priority_one;
			end else if (paddr == SHCC_OFF_PRI2) begin
				prdata <= handler_priority_two;
			end else if (paddr == SHCC_OFF_PRI3) begin
				prdata <= handler_priority_three;
			end else if (paddr == SHCC_OFF_HCS) begin
				prdata <= handler_control_state;
			end else if (paddr == SHCC_OFF_EVT) begin
				prdata <= event_status;
			end else begin
				prdata <= SHCC_ZERO;
				pslverr <= 1'b1;
			end
		end else if (rd_acc || !psel) begin
			prdata <= SHCC_ZERO;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Stack alignment on entry and restore on return
	// ----------------------------------------------------------------
	// The frame goes below the realigned pointer; the pad flag travels
	// in the stacked status word so return can undo it exactly.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			entry_sp_out <= SHCC_ZERO;
			entry_psr_out <= SHCC_ZERO;
		end else if (entry_req) begin
			if (config_control[SHCC_CFG_STKAL]) begin
				entry_sp_out <= entry_sp & SHCC_DWORD_ALIGN;
				entry_psr_out <= (entry_psr & ~(32'h1 << SHCC_PSR_ALIGN)) |
					({31'h0, entry_sp[2]} << SHCC_PSR_ALIGN);
			end else begin
				entry_sp_out <= entry_sp & SHCC_WORD_ALIGN;
				entry_psr_out <= entry_psr & ~(32'h1 << SHCC_PSR_ALIGN);
			end
		end
	end

	// Return adds the pad word back when the stacked flag says so
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			return_sp_out <= SHCC_ZERO;
		end else if (return_req) begin
			return_sp_out <= return_psr[SHCC_PSR_ALIGN] ?
				(return_sp | SHCC_FOUR) : return_sp;
		end
	end

	// ----------------------------------------------------------------
	// Divide by zero
	// ----------------------------------------------------------------
	// Signed result sign fixed up after an unsigned divide
	always_comb begin
		mag_q = SHCC_ZERO;
		next_quot = SHCC_ZERO;
		if (div_den != SHCC_ZERO) begin
			mag_q = shcc_mag(div_num, div_signed) /
				shcc_mag(div_den, div_signed);
			next_quot = (div_signed && (div_num[31] ^ div_den[31])) ?
				(SHCC_ZERO - mag_q) : mag_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			div_quot <= SHCC_ZERO;
			div_fault <= 1'b0;
		end else begin
			div_fault <= div_req && div_den == SHCC_ZERO &&
				config_control[SHCC_CFG_DIVZ];
			if (div_req) begin
				div_quot <= next_quot;
			end
		end
	end

	// ----------------------------------------------------------------
	// Unaligned access checks
	// ----------------------------------------------------------------
	assign misaligned = (mem_size == 2'h1 && mem_addr_lo[0]) ||
		(mem_size == 2'h2 && mem_addr_lo != 2'h0);

	// Multiple and doubleword forms fault whatever the trap bit says
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			unalign_fault <= 1'b0;
		end else begin
			unalign_fault <= mem_req && misaligned &&
				(mem_multi || config_control[SHCC_CFG_UNALIGN]);
		end
	end

	// ----------------------------------------------------------------
	// Bus faults at high priority
	// ----------------------------------------------------------------
	// Ignoring is only safe when the handler lives in trusted memory
	assign lockup_evt = dbus_err && high_prio &&
		!config_control[SHCC_CFG_BFIGN];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bus_err_drop <= 1'b0;
			lockup <= 1'b0;
		end else begin
			bus_err_drop <= dbus_err && high_prio &&
				config_control[SHCC_CFG_BFIGN];
			lockup <= lockup_evt;
		end
	end

	// ----------------------------------------------------------------
	// Fault escalation when its handler is disabled
	// ----------------------------------------------------------------
	always_comb begin
		case (fault_kind)
			SHCC_FK_MEM: fault_ena = handler_control_state[SHCC_HCS_MEMENA];
			SHCC_FK_BUS: fault_ena = handler_control_state[SHCC_HCS_BUSENA];
			SHCC_FK_USG: fault_ena = handler_control_state[SHCC_HCS_USGENA];
			default: fault_ena = 1'b0;
		endcase
	end

	assign hard_evt = fault_req && !fault_ena;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fault_taken <= 1'b0;
			hard_fault <= 1'b0;
		end else begin
			fault_taken <= fault_req && fault_ena;
			hard_fault <= hard_evt;
		end
	end

	// ----------------------------------------------------------------
	// Thread return policy and trigger register access
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			thread_ret_ok <= 1'b0;
			trig_grant <= 1'b0;
		end else begin
			thread_ret_ok <= thread_ret_req && (!others_active ||
				config_control[SHCC_CFG_THREAD]);
			trig_grant <= trig_req && (trig_priv ||
				config_control[SHCC_CFG_UNPRIV]);
		end
	end

endmodule

`default_nettype wire

/* dv/shcc_checker.sv */
// Concurrent checks for the system handler config and control block.
// Assumes a bind to shcc_top; the config word is shadowed from APB writes.
`timescale 1ns/1ps
`default_nettype none
module shcc_checker
	import shcc_pkg::*;
(
	input wire logic clk_sys, sys_rst, // Clock, reset
	input wire logic psel, penable, pwrite, pready, // APB control
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB strobes
	input wire logic div_req, div_fault, // Divide
	input wire logic [31:0] div_den, div_quot, // Divide data
	input wire logic mem_req, mem_multi, unalign_fault, // Access
	input wire logic [1:0] mem_size, mem_addr_lo, // Access shape
	input wire logic trig_req, trig_priv, trig_grant, // Trigger
	input wire logic thread_ret_req, others_active, thread_ret_ok, // Thread
	input wire logic dbus_err, high_prio, bus_err_drop, lockup, // Bus
	input wire logic entry_req, return_req, // Stack strobes
	input wire logic [31:0] entry_sp, entry_sp_out, entry_psr_out, // Entry
	input wire logic [31:0] return_sp, return_psr, return_sp_out // Return
);
	// ----------------------------------------------------------------
	// Config shadow
	// ----------------------------------------------------------------
	logic [31:0] cfg_sh;
	logic [31:0] lane_m;
	assign lane_m = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	// Lands at the ready edge, the same edge the slave commits
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cfg_sh <= SHCC_ZERO;
		end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
			cfg_sh <= (cfg_sh & ~lane_m) | (pwdata & lane_m & SHCC_CFG_MASK);
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_div_trap;
		div_req && div_den == SHCC_ZERO |=> div_fault == $past(cfg_sh[4]);
	endproperty
	a_div_trap: assert property (p_div_trap)
		else $error("divide trap does not follow its enable");
	property p_div_zero;
		div_req && div_den == SHCC_ZERO |=> div_quot == SHCC_ZERO;
	endproperty
	a_div_zero: assert property (p_div_zero)
		else $error("zero divisor gave a nonzero quotient");
	property p_unalign;
		mem_req && !mem_multi && mem_size == 2'h1 && mem_addr_lo[0]
			|=> unalign_fault == $past(cfg_sh[3]);
	endproperty
	a_unalign: assert property (p_unalign)
		else $error("unaligned halfword trap wrong");
	property p_multi;
		mem_req && mem_multi && mem_size == 2'h2 && mem_addr_lo != 2'h0
			|=> unalign_fault;
	endproperty
	a_multi: assert property (p_multi)
		else $error("unaligned multiple access did not fault");
	property p_trig;
		trig_req && !trig_priv |=> trig_grant == $past(cfg_sh[1]);
	endproperty
	a_trig: assert property (p_trig)
		else $error("unprivileged trigger grant wrong");
	property p_thread;
		thread_ret_req && others_active |=> thread_ret_ok == $past(cfg_sh[0]);
	endproperty
	a_thread: assert property (p_thread)
		else $error("thread return decision wrong");
	property p_bfign;
		dbus_err && high_prio |=> bus_err_drop == $past(cfg_sh[8])
			&& lockup == !$past(cfg_sh[8]);
	endproperty
	a_bfign: assert property (p_bfign)
		else $error("bus fault ignore or lock-up wrong");
	property p_align;
		entry_req |=> entry_sp_out == ($past(entry_sp)
			& ($past(cfg_sh[9]) ? 32'hFFFFFFF8 : 32'hFFFFFFFC));
	endproperty
	a_align: assert property (p_align)
		else $error("entry stack alignment wrong");
	property p_psr;
		entry_req |=> entry_psr_out[9] == ($past(cfg_sh[9]) & $past(entry_sp[2]));
	endproperty
	a_psr: assert property (p_psr)
		else $error("stacked realign flag wrong");
	property p_ret;
		return_req |=> return_sp_out == ($past(return_sp)
			| ($past(return_psr[9]) ? 32'h00000004 : 32'h00000000));
	endproperty
	a_ret: assert property (p_ret)
		else $error("return stack restore wrong");
endmodule
bind shcc_top shcc_checker shcc_checker_inst (
	.clk_sys, .sys_rst, .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
	.pstrb, .div_req, .div_fault, .div_den, .div_quot, .mem_req, .mem_multi,
	.unalign_fault, .mem_size, .mem_addr_lo, .trig_req, .trig_priv,
	.trig_grant, .thread_ret_req, .others_active, .thread_ret_ok, .dbus_err,
	.high_prio, .bus_err_drop, .lockup, .entry_req, .return_req, .entry_sp,
	.entry_sp_out, .entry_psr_out, .return_sp, .return_psr, .return_sp_out);
`default_nettype wire

/* dv/shcc_tb.sv */
// Self-checking bench for the system handler config and control block.
// Assumes a one wait-state APB slave and one-cycle core strobes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module system_handler_config_control_tb;
	import shcc_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr;
	logic entry_req = 1'b0, return_req = 1'b0, thread_ret_req = 1'b0;
	logic div_req = 1'b0, div_signed = 1'b0, mem_req = 1'b0, mem_multi = 1'b0;
	logic dbus_err = 1'b0, high_prio = 1'b0, fault_req = 1'b0;
	logic trig_req = 1'b0, trig_priv = 1'b0, others_active = 1'b0;
	logic [1:0] mem_size = 2'h0, mem_addr_lo = 2'h0, fault_kind = 2'h0;
	logic [31:0] entry_sp = 32'h0, entry_psr = 32'h0, return_sp = 32'h0;
	logic [31:0] return_psr = 32'h0, div_num = 32'h0, div_den = 32'h0;
	logic [31:0] entry_sp_out, entry_psr_out, return_sp_out, div_quot;
	logic thread_ret_ok, div_fault, unalign_fault, bus_err_drop, lockup;
	logic fault_taken, hard_fault, trig_grant;
	int n_fail = 0, samples_checked = 0;
	shcc_top shcc_top_inst (
		.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .entry_req, .entry_sp, .entry_psr,
		.entry_sp_out, .entry_psr_out, .return_req, .return_sp, .return_psr,
		.return_sp_out, .thread_ret_req, .others_active, .thread_ret_ok,
		.div_req, .div_num, .div_den, .div_signed, .div_quot, .div_fault,
		.mem_req, .mem_size, .mem_multi, .mem_addr_lo, .unalign_fault,
		.dbus_err, .high_prio, .bus_err_drop, .lockup, .fault_req, .fault_kind,
		.fault_taken, .hard_fault, .trig_req, .trig_priv, .trig_grant);
	always #25 clk_sys = ~clk_sys;
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	// Holds the request until ready is sampled; bounded so a hang counts
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n == 16) n_fail++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, s, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, 4'h0, r, e);
		`CHK(r, x)
	endtask
	// Reset values, stored bits, byte lanes and an unmapped hole
	task automatic t_regs();
		logic [7:0] offs [5];
		logic [31:0] msk [5];
		logic [31:0] r;
		logic e;
		offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
		msk = '{SHCC_CFG_MASK, SHCC_PRI1_MASK, SHCC_PRI2_MASK, SHCC_PRI3_MASK,
			SHCC_HCS_MASK};
		rd(SHCC_OFF_EVT, 32'h0);
		for (int i = 0; i < 5; i++) begin
			rd(offs[i], 32'h0);
			wr(offs[i], 32'hFFFFFFFF);
			rd(offs[i], msk[i]);
			wr(offs[i], 32'h0);
		end
		wr(SHCC_OFF_PRI1, 32'hFFFFFFFF, 4'h2);
		rd(SHCC_OFF_PRI1, 32'h0000F000);
		wr(SHCC_OFF_PRI1, 32'h0);
		apb(1'b1, 8'h18, 32'hFFFFFFFF, 4'hF, r, e);
		`CHK(e, 1'b1)
		apb(1'b0, 8'h18, 32'h0, 4'h0, r, e);
		`CHK({e, r}, {1'b1, 32'h0})
	endtask
	// All core strobes but fault_req share one cycle; b selects the second stimulus set
	task automatic t_core(input logic c, input logic b);
		wr(SHCC_OFF_CFG, c ? SHCC_CFG_MASK : SHCC_ZERO);
		@(posedge clk_sys);
		{div_req, mem_req, trig_req, thread_ret_req} <= 4'hF;
		{entry_req, return_req, dbus_err} <= 3'h7;
		div_num <= b ? 32'hFFFFFF9C : 32'h00000064;
		div_den <= b ? 32'h00000007 : 32'h0;
		div_signed <= b;
		mem_size <= b ? 2'h2 : 2'h1;
		mem_addr_lo <= b ? 2'h2 : 2'h1;
		mem_multi <= b;
		trig_priv <= b;
		others_active <= !b;
		high_prio <= !b;
		entry_sp <= b ? 32'h00001000 : 32'h00001004;
		return_sp <= 32'h00002000;
		entry_psr <= 32'h01000200;
		return_psr <= b ? 32'h0 : 32'h00000200;
		@(posedge clk_sys);
		{div_req, mem_req, trig_req, thread_ret_req} <= 4'h0;
		{entry_req, return_req, dbus_err} <= 3'h0;
		#1;
		`CHK(div_quot, b ? 32'hFFFFFFF2 : 32'h0)
		`CHK(div_fault, !b && c)
		`CHK(unalign_fault, b || c)
		`CHK(trig_grant, b || c)
		`CHK(thread_ret_ok, b || c)
		`CHK({bus_err_drop, lockup}, {!b && c, !b && !c})
		`CHK(entry_sp_out, (b || c) ? 32'h00001000 : 32'h00001004)
		`CHK(entry_psr_out, (!b && c) ? 32'h01000200 : 32'h01000000)
		`CHK(return_sp_out, b ? 32'h00002000 : 32'h00002004)
	endtask
	// Disabled faults escalate; enabled ones set their pending bit
	task automatic t_fault();
		logic [31:0] pb;
		for (int en = 0; en < 2; en++) begin
			for (int k = 0; k < 4; k++) begin
				wr(SHCC_OFF_HCS, en == 1 ? 32'h00070000 : 32'h0);
				@(posedge clk_sys);
				fault_req <= 1'b1;
				fault_kind <= 2'(k);
				@(posedge clk_sys);
				fault_req <= 1'b0;
				#1;
				`CHK({fault_taken, hard_fault}, {en == 1 && k < 3, en == 0 || k == 3})
				pb = (k == 3) ? 32'h0 : 32'h00001000 << ((k + 1) % 3);
				if (en == 1) rd(SHCC_OFF_HCS, 32'h00070000 | pb);
			end
		end
		rd(SHCC_OFF_EVT, 32'h00000003);
		wr(SHCC_OFF_EVT, 32'h00000003);
		rd(SHCC_OFF_EVT, 32'h0);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_regs();
		t_core(1'b1, 1'b0);
		t_core(1'b1, 1'b1);
		t_core(1'b0, 1'b0);
		t_core(1'b0, 1'b1);
		t_fault();
		report_and_stop();
	end
	// Watchdog: the sequence needs a few hundred cycles at most
	initial begin
		#(4000 * 50);
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire
